/* File: shared/serial_rom_boot_loader_regs.vh */
// Register map, field positions, reset values and timing counts of the serial ROM boot loader
`ifndef SERIAL_ROM_BOOT_LOADER_REGS_VH
`define SERIAL_ROM_BOOT_LOADER_REGS_VH

// Register byte offsets
`define OFS_STATUS 8'h00
`define OFS_EXT_LEN 8'h04
`define OFS_LOAD_COUNT 8'h08
`define OFS_EXT_COUNT 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// Status register fields
`define ST_PHASE_LSB 0
`define ST_ROM1_BUSY 2
`define ST_ROM2_UNREAD 3
`define ST_DATA_BIT 4

// Interrupt event bits
`define EV_LOAD_DONE 0
`define EV_EXT_DONE 1
`define EV_TOGGLE_FAST 2
`define EV_WIDTH 3

// Reset values
`define EXT_LEN_RESET 15'h4000
`define IRQ_MASK_RESET 3'h0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: clock period and 500 ns extension bit window, both in ns
`define CLK_PERIOD_NS 100
`define EXT_BIT_NS 500
// Least spacing rounds up, longest delay rounds down
`define TOGGLE_GAP_CYCLES ((`EXT_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_VALID_CYCLES (`EXT_BIT_NS / `CLK_PERIOD_NS)

`endif

/* File: rtl/pin_sync_edge.v */
// Two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module pin_sync_edge (
  input wire aclk,
  input wire aresetn,
  input wire pin,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg sync_r;
  reg last_r;

  // Only sync_r reads meta_r; edges come from the settled stages
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule // pin_sync_edge

/* File: rtl/serial_rom_boot_loader.v */
// Serial ROM boot loader: primary cache image stream, extension ROM stream, AXI4-Lite registers
//
// Notes on behaviour
// [R1] The 16KB primary ROM is shifted into the processor only after a power-up reset.
// [R2] Cache blocks go out in ascending order, block zero to block 255, each with all its fields.
// [R3] When the primary image is done the data path moves to the extension ROM by itself.
// [R4] Software reads the extension ROM by toggling the transmit bit and sampling the receive bit.
// [R5] Each extension bit is valid 500ns after load completion or a rising transmit toggle.
// [R6] The reader leaves at least 500ns between any two transmit toggle transitions.
// [R7] The extension ROM is presented once per hard reset; reading again needs another reset.
// [R8] The extension stream is readable at once, with no unused primary remainder to clock.
// [R9] The board micro follows progress by sampling the read status of each ROM.
// [R10] The micro talks to the processor only after all ROMs are read or an error is seen.
// [R11] The micro drives its serial output to 1, enables the link and counts ROM clocks.
// [R12] The first read status stays set until the primary cache load has completed.
// [R13] The second read status stays set while the extension ROM is unread.
// [R14] The micro's link disable comes out of reset as 1.
// [R15] The micro's serial line is active only while its port 2 bit 7 is clear.
// [R16] Hard reset returns the bit pointer and ROM select to the primary ROM at bit zero.
`timescale 1ns/1ps
`include "serial_rom_boot_loader_regs.vh"
module serial_rom_boot_loader #(
  parameter LOAD_BITS = 131072,
  parameter ADDR_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire proc_serial_clk,
  input wire serial_transmit_toggle_bit,
  output wire serial_receive_bit,
  output wire rom1_read_status,
  output wire rom2_read_status,
  output wire [14:0] rom_addr,
  input wire [7:0] rom_data,
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  output wire irq
);
  localparam PH_LOAD = 2'b00;
  localparam PH_EXT = 2'b01;
  localparam PH_DONE = 2'b10;
  localparam [31:0] LOAD_LAST_W = LOAD_BITS - 1;
  localparam [17:0] LOAD_LAST = LOAD_LAST_W[17:0];
  localparam [31:0] GAP_W = `TOGGLE_GAP_CYCLES;
  localparam [3:0] GAP_CYC = GAP_W[3:0];

  // Pick one bit of a ROM byte, most significant bit first
  function bit_of;
    input [7:0] byte_in;
    input [2:0] sel;
    begin
      bit_of = byte_in[3'd7 - sel];
    end
  endfunction

  // Write strobes merged into the old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  wire sclk_rise;
  wire tgl_rise;
  wire tgl_fall;

  reg [1:0] phase_r;
  reg [17:0] load_idx_r;
  reg [17:0] ext_idx_r;
  reg [14:0] rom_addr_r;
  reg [2:0] bit_sel_r;
  reg fetch_r;
  reg data_bit_r;
  reg [3:0] gap_cnt_r;
  reg [14:0] ext_len_r;
  reg [`EV_WIDTH-1:0] irq_status_r;
  reg [`EV_WIDTH-1:0] irq_status_nxt;
  reg [`EV_WIDTH-1:0] irq_mask_r;
  reg [`EV_WIDTH-1:0] ev_set;
  reg aw_got_r;
  reg w_got_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [31:0] rd_word;
  reg rd_ok;

  // Both link inputs come from the processor's domain
  pin_sync_edge sclk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(proc_serial_clk),
    .level(),
    .rise(sclk_rise),
    .fall()
  );

  pin_sync_edge tgl_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(serial_transmit_toggle_bit),
    .level(),
    .rise(tgl_rise),
    .fall(tgl_fall)
  );

  wire load_last = (phase_r == PH_LOAD) && (load_idx_r == LOAD_LAST);
  wire [17:0] ext_bits = {ext_len_r, 3'b000};
  wire ext_last = (phase_r == PH_EXT) && (ext_idx_r + 18'h00001 >= ext_bits);
  wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  wire [31:0] ext_len_merged = merge({17'h00000, ext_len_r}, wdata_r, wstrb_r);

  // Bit pointer and ROM select; hard reset is the only way back to bit zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_r <= PH_LOAD; // R16
      load_idx_r <= 18'h00000; // R16
      ext_idx_r <= 18'h00000; // R16
      rom_addr_r <= 15'h0000; // R16
      bit_sel_r <= 3'h0;
      fetch_r <= 1'b1; // R1
    end
    else
    begin
      fetch_r <= 1'b0;
      case (phase_r)
        PH_LOAD:
        begin
          if (sclk_rise)
          begin
            if (load_last)
            begin
              // Switch straight to extension bit zero, no primary tail to clock
              phase_r <= PH_EXT; // R3
              rom_addr_r <= {1'b1, 14'h0000}; // R8
              bit_sel_r <= 3'h0;
              fetch_r <= 1'b1; // R5
            end
            else
            begin
              // Ascending bit order walks blocks zero to 255 in turn
              load_idx_r <= load_idx_r + 18'h00001; // R2
              rom_addr_r <= {1'b0, load_idx_r[16:3] + {13'h0000, &load_idx_r[2:0]}}; // R2
              bit_sel_r <= load_idx_r[2:0] + 3'h1; // R2
              fetch_r <= 1'b1; // R1
            end
          end
        end
        PH_EXT:
        begin
          if (tgl_rise)
          begin
            if (ext_last)
              phase_r <= PH_DONE; // R7
            else
            begin
              ext_idx_r <= ext_idx_r + 18'h00001; // R4
              rom_addr_r <= {1'b1, ext_idx_r[16:3] + {13'h0000, &ext_idx_r[2:0]}}; // R4
              bit_sel_r <= ext_idx_r[2:0] + 3'h1; // R4
              fetch_r <= 1'b1; // R5
            end
          end
        end
        PH_DONE:
        begin
          // Stream is spent until the next hard reset
          phase_r <= PH_DONE; // R7
        end
        default:
        begin
          phase_r <= PH_LOAD;
        end
      endcase
    end
  end

  // ROM byte read one cycle after the address moves; bit ready well inside 500 ns
  always @(posedge aclk)
  begin
    if (!aresetn)
      data_bit_r <= 1'b0;
    else if (phase_r == PH_DONE)
      data_bit_r <= 1'b0; // R7
    else if (fetch_r)
      data_bit_r <= bit_of(rom_data, bit_sel_r); // R5
  end

  // Time since the last toggle transition, saturating at the least gap
  always @(posedge aclk)
  begin
    if (!aresetn)
      gap_cnt_r <= GAP_CYC;
    else if (tgl_rise | tgl_fall)
      gap_cnt_r <= 4'h1;
    else if (gap_cnt_r < GAP_CYC)
      gap_cnt_r <= gap_cnt_r + 4'h1;
  end

  // Events for the sticky status register
  always @*
  begin
    ev_set = {`EV_WIDTH{1'b0}};
    ev_set[`EV_LOAD_DONE] = sclk_rise & load_last; // R12
    ev_set[`EV_EXT_DONE] = tgl_rise & ext_last; // R13
    // Sampled pin edges can shift by a cycle; any spacing below the least gap in the extension phase is flagged, with no margin
    ev_set[`EV_TOGGLE_FAST] = (phase_r == PH_EXT) & (tgl_rise | tgl_fall)
      & (gap_cnt_r < GAP_CYC); // R6
    irq_status_nxt = irq_status_r;
    if (wr_fire && awaddr_r == `OFS_IRQ_STATUS && wstrb_r[0])
      irq_status_nxt = irq_status_r & ~wdata_r[`EV_WIDTH-1:0];
    // Set wins over a clear in the same cycle
    irq_status_nxt = irq_status_nxt | ev_set;
  end

  // Write channel: address and data accepted in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        case (awaddr_r)
          `OFS_EXT_LEN, `OFS_IRQ_STATUS, `OFS_IRQ_MASK: bresp_r <= `RESP_OKAY;
          default: bresp_r <= `RESP_SLVERR;
        endcase
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  // Writable registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_len_r <= `EXT_LEN_RESET;
      irq_mask_r <= `IRQ_MASK_RESET;
      irq_status_r <= {`EV_WIDTH{1'b0}};
    end
    else
    begin
      irq_status_r <= irq_status_nxt;
      if (wr_fire && awaddr_r == `OFS_EXT_LEN)
        ext_len_r <= (ext_len_merged > 32'h00004000)
          ? `EXT_LEN_RESET : ext_len_merged[14:0];
      if (wr_fire && awaddr_r == `OFS_IRQ_MASK && wstrb_r[0])
        irq_mask_r <= wdata_r[`EV_WIDTH-1:0];
    end
  end

  // Read decode
  always @*
  begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (araddr)
      `OFS_STATUS:
      begin
        rd_word[`ST_PHASE_LSB +: 2] = phase_r;
        rd_word[`ST_ROM1_BUSY] = rom1_read_status;
        rd_word[`ST_ROM2_UNREAD] = rom2_read_status;
        rd_word[`ST_DATA_BIT] = data_bit_r;
      end
      `OFS_EXT_LEN: rd_word[14:0] = ext_len_r;
      `OFS_LOAD_COUNT: rd_word[17:0] = load_idx_r;
      `OFS_EXT_COUNT: rd_word[17:0] = ext_idx_r;
      `OFS_IRQ_STATUS: rd_word[`EV_WIDTH-1:0] = irq_status_r;
      `OFS_IRQ_MASK: rd_word[`EV_WIDTH-1:0] = irq_mask_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel: one read at a time, data registered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_r && rready)
      rvalid_r <= 1'b0;
  end

  assign awready = ~aw_got_r & ~bvalid_r;
  assign wready = ~w_got_r & ~bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = ~rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign rom_addr = rom_addr_r;
  assign serial_receive_bit = data_bit_r; // R5
  assign rom1_read_status = (phase_r == PH_LOAD); // R12
  assign rom2_read_status = (phase_r != PH_DONE); // R13
  assign irq = |(irq_status_r & irq_mask_r);
endmodule // serial_rom_boot_loader

/* File: sim/serial_rom_boot_loader_assertions.sv */
// Port-level checker for the serial ROM boot loader
`timescale 1ns/1ps
module serial_rom_boot_loader_assertions #(
  parameter LOAD_BITS = 131072,
  parameter ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic proc_serial_clk,
  input wire logic serial_transmit_toggle_bit,
  input wire logic serial_receive_bit,
  input wire logic rom1_read_status,
  input wire logic rom2_read_status,
  input wire logic [14:0] rom_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both ROMs pending and primary bit zero selected after reset
  chk_reset_state: assert property ($rose(aresetn) |-> rom1_read_status && rom2_read_status
    && rom_addr == 15'h0000) else $error("bad state after reset");
  chk_load_once: assert property (!rom1_read_status |=> !rom1_read_status)
    else $error("primary load restarted");
  chk_ext_once: assert property (!rom2_read_status |=> !rom2_read_status)
    else $error("extension presented twice");
  chk_rom_order: assert property (!rom2_read_status |-> !rom1_read_status)
    else $error("extension done before load");
  chk_ext_switch: assert property ($fell(rom1_read_status) |-> rom_addr == 15'h4000)
    else $error("extension not at bit zero");
  chk_primary_sel: assert property (rom1_read_status |-> !rom_addr[14])
    else $error("extension selected during load");
  // Without a toggle the extension pointer must not move
  chk_ext_quiet: assert property ((!rom1_read_status && $stable(serial_transmit_toggle_bit)) [*6]
    |=> $stable(rom_addr)) else $error("extension moved without toggle");
  chk_load_quiet: assert property ((rom1_read_status && $stable(proc_serial_clk)) [*6]
    |=> $stable(rom_addr)) else $error("load moved without serial clock");
  chk_done_zero: assert property (!rom2_read_status |=> !serial_receive_bit)
    else $error("data after extension end");
  cov_load_done: cover property ($fell(rom1_read_status));
  cov_ext_done: cover property ($fell(rom2_read_status));
  cov_toggle: cover property ($rose(serial_transmit_toggle_bit) && !rom1_read_status);
endmodule // serial_rom_boot_loader_assertions

bind serial_rom_boot_loader serial_rom_boot_loader_assertions #(.LOAD_BITS(LOAD_BITS),
  .ADDR_W(ADDR_W)) chk_i (.aclk(aclk), .aresetn(aresetn), .proc_serial_clk(proc_serial_clk),
  .serial_transmit_toggle_bit(serial_transmit_toggle_bit), .serial_receive_bit(serial_receive_bit),
  .rom1_read_status(rom1_read_status), .rom2_read_status(rom2_read_status), .rom_addr(rom_addr));

/* File: sim/rom_proc_model.sv */
// Serial ROM contents and the processor's serial load clock
`timescale 1ns/1ps
module rom_proc_model (
  input wire logic run,
  input wire logic rom1_read_status,
  input wire logic rom2_read_status,
  input wire logic [14:0] rom_addr,
  output logic [7:0] rom_data,
  output logic proc_serial_clk
);
  logic [7:0] mem [0:32767];
  integer seed;
  integer i;
  // Random image so a stuck or swapped bit shows
  initial
  begin
    seed = 32'hBA1901E5;
    proc_serial_clk = 1'b0;
    for (i = 0; i < 32768; i = i + 1)
      mem[i] = 8'($random(seed));
  end
  assign rom_data = mem[rom_addr];
  // Board micro: link held off from reset, opened only to watch load clocks
  logic comm_disable = 1'b1;
  logic micro_port2_bit7 = 1'b0;
  logic micro_line_out = 1'b0;
  logic talk_ok = 1'b0;
  int sclk_count = 0;
  always @(posedge run)
  begin
    micro_line_out = 1'b1;
    comm_disable = 1'b0;
  end
  always @(posedge proc_serial_clk)
    if (micro_line_out && !comm_disable && !micro_port2_bit7)
      sclk_count++;
  // Talking is allowed only once both ROMs have been read in order
  always @(negedge rom2_read_status)
    talk_ok = !rom1_read_status;
  // 800 ns load clock; stands still once the load is done
  always
  begin
    wait (run);
    #437;
    while (rom1_read_status)
    begin
      #400 proc_serial_clk = 1'b1;
      #400 proc_serial_clk = 1'b0;
    end
    wait (!run);
  end
endmodule // rom_proc_model

/* File: sim/test_serial_rom_boot_loader.sv */
// Self-checking bench for the serial ROM boot loader
`timescale 1ns/1ps
module test_serial_rom_boot_loader;
  logic aclk, psclk, rx, rom1, rom2, awready, wready, bvalid, arready, rvalid, irq;
  logic aresetn = 1'b0, tog = 1'b0, run = 1'b0, smp = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rom_data;
  logic [31:0] wdata = 32'h0, rdata;
  logic [14:0] rom_addr;
  logic [1:0] bresp, rresp;
  logic bit_q[$];
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  int error_cnt = 0, num_checks = 0, cyc = 0, j;
  serial_rom_boot_loader #(.LOAD_BITS(64)) uut (.aclk(aclk), .aresetn(aresetn),
    .proc_serial_clk(psclk), .serial_transmit_toggle_bit(tog), .serial_receive_bit(rx),
    .rom1_read_status(rom1), .rom2_read_status(rom2), .rom_addr(rom_addr), .rom_data(rom_data),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(1'b1), .irq(irq));
  rom_proc_model rom (.run(run), .rom1_read_status(rom1), .rom2_read_status(rom2),
    .rom_addr(rom_addr),
    .rom_data(rom_data), .proc_serial_clk(psclk));
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  function automatic logic ebit(input int k, input int base);
    return rom.mem[base + k / 8][7 - k % 8];
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Write: address and data offered together, bready held high throughout
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    // Only the writable offsets answer okay, the rest a slave error
    wr_q.push_back((a == 8'h04 || a == 8'h10 || a == 8'h14) ? 2'h0 : 2'h2);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask
  task automatic smp_bit(input logic e);
    bit_q.push_back(e);
    smp <= 1'b1;
    @(posedge aclk);
    smp <= 1'b0;
  endtask
  // Bits judged when the processor clocks them or software samples
  always @(posedge psclk)
    chk(rx, bit_q.pop_front());
  // Software samples are taken mid-cycle, clear of the launching edge
  always @(negedge aclk)
    if (smp) chk(rx, bit_q.pop_front());
  // Write answers judged at the handshake
  always @(posedge aclk)
    if (bvalid) chk(bresp, wr_q.pop_front());
  // Read answers judged at the handshake
  always @(posedge aclk)
    if (rvalid) chk({rresp, rdata}, rd_q.pop_front());
  // Cut a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(rom1, 1'b1);
    chk(rom2, 1'b1);
    wr(8'h08, 32'h1);
    rd(8'h08, 34'h0);
    wr(8'h04, 32'h5000);
    rd(8'h04, 34'h4000);
    wr(8'h04, 32'h2);
    rd(8'h04, 34'h2);
    rd(8'h14, 34'h0);
    wr(8'h14, 32'h7);
    rd(8'h20, {2'h2, 32'h0});
    rd(8'h00, {29'h0, ebit(0, 0), 4'hC});
    for (j = 0; j < 64; j++) bit_q.push_back(ebit(j, 0));
    run <= 1'b1;
    while (rom1) @(posedge aclk);
    chk(rom2, 1'b1);
    chk(rom.sclk_count, 64);
    repeat (4) @(posedge aclk);
    smp_bit(ebit(0, 16384));
    rd(8'h00, {29'h0, ebit(0, 16384), 4'h9});
    rd(8'h08, 34'h3F);
    // One gap kept short on purpose to raise the spacing event
    for (j = 1; j <= 16; j++)
    begin
      tog <= 1'b1;
      repeat (5) @(posedge aclk);
      if (j < 16) smp_bit(ebit(j, 16384));
      tog <= 1'b0;
      repeat (j == 4 ? 2 : 5) @(posedge aclk);
    end
    chk(rom2, 1'b0);
    chk(rom.talk_ok, 1'b1);
    rd(8'h0C, 34'hF);
    chk(irq, 1'b1);
    rd(8'h10, 34'h7);
    wr(8'h10, 32'h1);
    rd(8'h10, 34'h6);
    wr(8'h14, 32'h0);
    chk(irq, 1'b0);
    wr(8'h10, 32'h6);
    rd(8'h10, 34'h0);
    tog <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(rx, 1'b0);
    rd(8'h00, 34'h2);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({rom1, rom2, rom_addr}, {2'h3, 15'h0});
    // Every noted expectation must have been met by an answer
    chk(bit_q.size() + rd_q.size() + wr_q.size(), 0);
    report_and_stop();
  end
endmodule // test_serial_rom_boot_loader
